// File: hdl/dpsf_host.sv
// host controller driving one port of a dual-port semaphore flag unit
// assumes the far device keeps its flag latches; chip select is held high so only flag space is reached
// Operation
// - flags active low: write zero claims, write one from same port releases
// - host drives flag select low, then address, oe and r/w like sram
// - host deasserts select or oe between successive polling reads
// - host claims by writing zero then reading the flag back
// - after a failed claim host keeps reading or writes one to withdraw
// - host start-up writes one to every flag from its port; here this is done only on an OP_INIT command, not on reset
`timescale 1ns/100ps
`default_nettype none
module dpsf_host (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_OP,
    input wire logic [2:0] CMD_INDEX,
    output logic CMD_READY,
    output logic RESP_VALID,
    output logic RESP_GRANTED,
    output logic RESP_FLAG,
    output logic RESP_ERROR,
    output logic CHIP_SELECT_N,
    output logic FLAG_SPACE_SELECT_N,
    output logic OUTPUT_ENABLE_N,
    output logic READ_WRITE_N,
    output logic [2:0] FLAG_INDEX_LINES,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE_N,
    input wire logic [15:0] DATA_IN
);
    ////////////////////////////////////////////////////////////////////////////
    dpsf_pkg::dpsf_state_e state_q, state_d;
    logic [dpsf_pkg::CNT_W-1:0] cnt_q, cnt_d;
    dpsf_pkg::dpsf_op_e op_q, op_d;
    logic [2:0] idx_q, idx_d;
    logic wbit_q, wbit_d;
    logic withdraw_q, withdraw_d;
    logic rd_done_q, rd_done_d;
    logic [7:0] polls_q, polls_d;
    logic flag_q, err_q, sample;
    logic [15:0] data_sync;

    dpsf_sync #(.W(dpsf_pkg::DATA_W)) u_sync (
        .clk(SYS_CLK),
        .din(DATA_IN),
        .dout(data_sync)
    );

    function automatic logic [dpsf_pkg::CNT_W-1:0] cyc(input int unsigned n);
        return dpsf_pkg::CNT_W'(n - 1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencing of pin cycles
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
        op_d = op_q;
        idx_d = idx_q;
        wbit_d = wbit_q;
        withdraw_d = withdraw_q;
        rd_done_d = rd_done_q;
        polls_d = polls_q;
        sample = 1'b0;
        unique case (state_q)
            dpsf_pkg::S_IDLE: begin
                if (CMD_VALID && CMD_READY) begin
                    op_d = dpsf_pkg::dpsf_op_e'(CMD_OP);
                    idx_d = CMD_INDEX;
                    withdraw_d = 1'b0;
                    rd_done_d = 1'b0;
                    polls_d = 8'h00;
                    if (dpsf_op_e_is_read(CMD_OP)) begin
                        state_d = dpsf_pkg::S_RWAIT;
                        cnt_d = cyc(dpsf_pkg::READ_CYC);
                    end else begin
                        // claim writes zero first; release and init write one
                        wbit_d = (CMD_OP != dpsf_pkg::OP_CLAIM);
                        if (CMD_OP == dpsf_pkg::OP_INIT) begin
                            idx_d = 3'h0;
                        end
                        state_d = dpsf_pkg::S_WSET;
                        cnt_d = cyc(dpsf_pkg::WSETUP_CYC);
                    end
                end
            end
            dpsf_pkg::S_WSET: begin
                if (cnt_q == '0) begin
                    state_d = dpsf_pkg::S_WPULSE;
                    cnt_d = cyc(dpsf_pkg::WPULSE_CYC);
                end
            end
            dpsf_pkg::S_WPULSE: begin
                if (cnt_q == '0) begin
                    state_d = dpsf_pkg::S_WEND;
                    cnt_d = cyc(dpsf_pkg::WHOLD_CYC);
                end
            end
            dpsf_pkg::S_WEND: begin
                if (cnt_q == '0) begin
                    state_d = dpsf_pkg::S_GAP;
                    cnt_d = cyc(dpsf_pkg::GAP_CYC);
                end
            end
            dpsf_pkg::S_RWAIT: begin
                if (cnt_q == '0) begin
                    sample = 1'b1;
                    rd_done_d = 1'b1;
                    state_d = dpsf_pkg::S_GAP;
                    cnt_d = cyc(dpsf_pkg::GAP_CYC);
                end
            end
            dpsf_pkg::S_GAP: begin
                if (cnt_q == '0) begin
                    state_d = dpsf_pkg::S_RESP;
                    if (op_q == dpsf_pkg::OP_INIT && idx_q != dpsf_pkg::LAST_IDX) begin
                        idx_d = idx_q + 3'h1;
                        state_d = dpsf_pkg::S_WSET;
                        cnt_d = cyc(dpsf_pkg::WSETUP_CYC);
                    end else if (op_q == dpsf_pkg::OP_CLAIM && !withdraw_q && rd_done_q && flag_q) begin
                        if (polls_q == dpsf_pkg::POLL_LIMIT) begin
                            // give up and withdraw the pending request
                            withdraw_d = 1'b1;
                            wbit_d = 1'b1;
                            state_d = dpsf_pkg::S_WSET;
                            cnt_d = cyc(dpsf_pkg::WSETUP_CYC);
                        end else begin
                            polls_d = polls_q + 8'h01; // keep reading
                            state_d = dpsf_pkg::S_RWAIT;
                            cnt_d = cyc(dpsf_pkg::READ_CYC);
                        end
                    end else if (op_q == dpsf_pkg::OP_CLAIM && !rd_done_q) begin
                        state_d = dpsf_pkg::S_RWAIT; // read back after the write
                        cnt_d = cyc(dpsf_pkg::READ_CYC);
                    end
                end
            end
            dpsf_pkg::S_RESP: begin
                state_d = dpsf_pkg::S_IDLE;
            end
            default: begin
                state_d = dpsf_pkg::S_IDLE;
            end
        endcase
    end

    function automatic logic dpsf_op_e_is_read(input logic [1:0] op);
        return op == dpsf_pkg::OP_READ;
    endfunction

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            state_q <= dpsf_pkg::S_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            op_q <= dpsf_pkg::OP_READ;
            idx_q <= 3'h0;
            wbit_q <= 1'b1;
            withdraw_q <= 1'b0;
            rd_done_q <= 1'b0;
            polls_q <= 8'h00;
        end else begin
            op_q <= op_d;
            idx_q <= idx_d;
            wbit_q <= wbit_d;
            withdraw_q <= withdraw_d;
            rd_done_q <= rd_done_d;
            polls_q <= polls_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag capture; a valid read shows the flag on all bits
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            flag_q <= 1'b1;
            err_q <= 1'b0;
        end else if (sample) begin
            flag_q <= data_sync[0];
            err_q <= !((&data_sync) || !(|data_sync));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins, registered from the next state
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            CHIP_SELECT_N <= 1'b1;
            FLAG_SPACE_SELECT_N <= 1'b1;
            OUTPUT_ENABLE_N <= 1'b1;
            READ_WRITE_N <= 1'b1;
            FLAG_INDEX_LINES <= 3'h0;
            DATA_OUT <= 16'h0000;
            DATA_OE_N <= 1'b1;
        end else begin
            CHIP_SELECT_N <= 1'b1;
            FLAG_SPACE_SELECT_N <= !(state_d inside {dpsf_pkg::S_WSET, dpsf_pkg::S_WPULSE,
                                                    dpsf_pkg::S_WEND, dpsf_pkg::S_RWAIT});
            OUTPUT_ENABLE_N <= (state_d != dpsf_pkg::S_RWAIT);
            READ_WRITE_N <= (state_d != dpsf_pkg::S_WPULSE);
            FLAG_INDEX_LINES <= idx_d;
            DATA_OUT <= {15'h0000, wbit_d};
            DATA_OE_N <= !(state_d inside {dpsf_pkg::S_WSET, dpsf_pkg::S_WPULSE, dpsf_pkg::S_WEND});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // user side
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            CMD_READY <= 1'b0;
            RESP_VALID <= 1'b0;
            RESP_GRANTED <= 1'b0;
            RESP_FLAG <= 1'b1;
            RESP_ERROR <= 1'b0;
        end else begin
            CMD_READY <= (state_d == dpsf_pkg::S_IDLE);
            RESP_VALID <= (state_d == dpsf_pkg::S_RESP);
            if (state_d == dpsf_pkg::S_RESP) begin
                RESP_GRANTED <= (op_q == dpsf_pkg::OP_CLAIM) && !withdraw_q && !flag_q;
                RESP_FLAG <= flag_q;
                RESP_ERROR <= err_q && rd_done_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic last_wbit_q;
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            last_wbit_q <= 1'b1;
        end else if (!READ_WRITE_N) begin
            last_wbit_q <= DATA_OUT[0];
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    a_ram_never_sel: assert property (CHIP_SELECT_N) else $error("chip select driven low");
    a_write_has_sel: assert property (!READ_WRITE_N |-> !FLAG_SPACE_SELECT_N && !DATA_OE_N && OUTPUT_ENABLE_N)
        else $error("write strobe without select or data");
    a_write_pulse_len: assert property ($fell(READ_WRITE_N) |-> !READ_WRITE_N ##1 !READ_WRITE_N ##1 READ_WRITE_N)
        else $error("write pulse length wrong");
    a_no_drive_read: assert property (!OUTPUT_ENABLE_N |-> DATA_OE_N)
        else $error("data driven during read");
    a_poll_gap: assert property ($rose(OUTPUT_ENABLE_N) |-> FLAG_SPACE_SELECT_N && OUTPUT_ENABLE_N)
        else $error("no gap between reads");
    a_claim_writes_zero: assert property (!READ_WRITE_N && op_q == dpsf_pkg::OP_CLAIM && !withdraw_q |-> !DATA_OUT[0])
        else $error("claim did not write zero");
    a_release_writes_one: assert property (!READ_WRITE_N && op_q != dpsf_pkg::OP_CLAIM |-> DATA_OUT[0])
        else $error("release or init did not write one");
    a_claim_read_back: assert property ($fell(OUTPUT_ENABLE_N) && op_q == dpsf_pkg::OP_CLAIM |-> !last_wbit_q || withdraw_q)
        else $error("claim read without prior zero write");
    a_fail_withdraws: assert property (RESP_VALID && op_q == dpsf_pkg::OP_CLAIM && !RESP_GRANTED |-> last_wbit_q)
        else $error("failed claim left a pending request");
    a_resp_one_cycle: assert property (RESP_VALID |=> !RESP_VALID && CMD_READY)
        else $error("response not a single pulse");

    c_claim_granted: cover property (RESP_VALID && RESP_GRANTED);
    c_claim_withdrawn: cover property (RESP_VALID && op_q == dpsf_pkg::OP_CLAIM && !RESP_GRANTED);
    c_init_done: cover property (RESP_VALID && op_q == dpsf_pkg::OP_INIT);
endmodule // dpsf_host
`default_nettype wire

// File: common/dpsf_pkg.sv
// constants for the host-side controller of a dual-port semaphore flag unit
// assumes one 25 MHz clock; the flag unit itself is asynchronous sram-style logic
package dpsf_pkg;
    localparam int unsigned CLK_NS = 40;
    localparam int unsigned FLAG_COUNT = 8;
    localparam int unsigned IDX_W = 3;
    localparam int unsigned DATA_W = 16;
    // pin timing in ns, as seen by this port
    localparam int unsigned T_WSETUP_NS = 40;
    localparam int unsigned T_WPULSE_NS = 80;
    localparam int unsigned T_WHOLD_NS = 40;
    localparam int unsigned T_READ_NS = 120;
    localparam int unsigned T_GAP_NS = 40;
    localparam int unsigned SYNC_STAGES = 2;
    // least times round up to whole cycles
    localparam int unsigned WSETUP_CYC = (T_WSETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WPULSE_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned WHOLD_CYC = (T_WHOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CNT_W = 4;
    localparam logic [7:0] POLL_LIMIT = 8'h10;
    localparam logic [IDX_W-1:0] LAST_IDX = 3'h7;
    // user commands
    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_CLAIM = 2'h1,
        OP_RELEASE = 2'h2,
        OP_INIT = 2'h3
    } dpsf_op_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WSET = 3'h1,
        S_WPULSE = 3'h2,
        S_WEND = 3'h3,
        S_RWAIT = 3'h4,
        S_GAP = 3'h5,
        S_RESP = 3'h6
    } dpsf_state_e;
endpackage

// File: hdl/dpsf_sync.sv
// two-stage synchroniser for a bus of pin inputs
// assumes the pins are stable while sampled as a word (flag reads are latched by the device)
`timescale 1ns/100ps
`default_nettype none
module dpsf_sync #(
    parameter int unsigned W = 16
) (
    input wire logic clk,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk) begin
        meta_q <= din;
        dout <= meta_q;
    end
endmodule // dpsf_sync
`default_nettype wire

// File: test/dpsf_dev_model.sv
// behavioural semaphore flag device: left port on pins, right port through port_write and view
// assumes the host keeps chip select high and drives sram-style flag cycles
`timescale 1ns/100ps
`default_nettype none
module dpsf_dev_model #(
    parameter int unsigned ACC_NS = 30
) (
    input wire logic cs_n,
    input wire logic sem_n,
    input wire logic oe_n,
    input wire logic rw_n,
    input wire logic [2:0] idx,
    input wire logic [15:0] dout,
    input wire logic dout_oe_n,
    output logic [15:0] din
);
    logic [1:0] owner [8]; // 0 free, 1 left, 2 right
    logic req_n [2][8];
    logic lat_q = 1'b1;
    logic rd_dly = 1'b0;
    logic bad_bus = 1'b0;
    wire logic rd_act;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic port_write(input int p, input logic [2:0] i, input logic v);
        req_n[p][i] = v;
        if (!v && owner[i] == 2'h0) owner[i] = 2'(p + 1);
        else if (v && owner[i] == 2'(p + 1)) owner[i] = req_n[1-p][i] ? 2'h0 : 2'(2 - p);
    endtask
    function automatic logic view(input int p, input logic [2:0] i);
        return owner[i] != 2'(p + 1);
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8; i++) begin
            owner[i] = 2'h1; // power-up garbage: left seems to hold every flag
            req_n[0][i] = 1'b0;
            req_n[1][i] = 1'b1;
        end
    end
    always @(posedge rw_n) begin
        if (!sem_n && cs_n && !dout_oe_n) port_write(0, idx, dout[0]);
    end
    assign rd_act = !sem_n && !oe_n && rw_n && cs_n;
    // wait past the launching edge so the index pins have settled
    always @(posedge rd_act) begin
        #1;
        lat_q <= view(0, idx);
    end
    always @(rd_act) rd_dly <= #ACC_NS rd_act;
    // released bus shows the inverse of the last value
    assign din = !rd_dly ? ~{16{lat_q}} : bad_bus ? {8'h00, {8{lat_q}}} : {16{lat_q}};
endmodule // dpsf_dev_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the host flag controller against a behavioural device
// assumes the device model answers reads after 100 ns and the right port is driven here
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [2:0] cmd_index = 3'h0;
    logic cmd_ready, resp_valid, resp_granted, resp_flag, resp_error;
    logic cs_n, sem_n, oe_n, rw_n, dout_oe_n;
    logic [2:0] idx;
    logic [15:0] dout, din;
    logic g_q, f_q, e_q;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #20 sys_clk = ~sys_clk;
    dpsf_host dut (.SYS_CLK(sys_clk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_INDEX(cmd_index), .CMD_READY(cmd_ready), .RESP_VALID(resp_valid), .RESP_GRANTED(resp_granted),
        .RESP_FLAG(resp_flag), .RESP_ERROR(resp_error), .CHIP_SELECT_N(cs_n), .FLAG_SPACE_SELECT_N(sem_n),
        .OUTPUT_ENABLE_N(oe_n), .READ_WRITE_N(rw_n), .FLAG_INDEX_LINES(idx), .DATA_OUT(dout),
        .DATA_OE_N(dout_oe_n), .DATA_IN(din));
    dpsf_dev_model #(.ACC_NS(100)) dev (.cs_n(cs_n), .sem_n(sem_n), .oe_n(oe_n), .rw_n(rw_n), .idx(idx),
        .dout(dout), .dout_oe_n(dout_oe_n), .din(din));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one command from the edge it is entered at; response fields kept in g_q f_q e_q
    task automatic run_cmd(input dpsf_pkg::dpsf_op_e op, input logic [2:0] i);
        int n;
        n = 0;
        cmd_op <= op;
        cmd_index <= i;
        cmd_valid <= 1'b1;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        while (resp_valid !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check("resp_valid", 16'(resp_valid), 16'h1);
        {g_q, f_q, e_q} = {resp_granted, resp_flag, resp_error};
        @(posedge sys_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        check("idle pins", {13'h0, cs_n, sem_n, oe_n}, 16'h7);
        run_cmd(dpsf_pkg::OP_INIT, 3'h0);
        for (int i = 0; i < 8; i++) begin
            run_cmd(dpsf_pkg::OP_READ, 3'(i));
            check("left flag", 16'(f_q), 16'h1);
            check("right flag", 16'(dev.view(1, 3'(i))), 16'h1);
            check("read error", 16'(e_q), 16'h0);
        end
        $display("test init done");
    endtask
    task automatic t_handover();
        run_cmd(dpsf_pkg::OP_CLAIM, 3'h3);
        check("granted", 16'(g_q), 16'h1);
        check("right view", 16'(dev.view(1, 3'h3)), 16'h1);
        dev.port_write(1, 3'h3, 1'b0);
        check("right pending", 16'(dev.view(1, 3'h3)), 16'h1);
        run_cmd(dpsf_pkg::OP_RELEASE, 3'h3);
        check("right owns", 16'(dev.view(1, 3'h3)), 16'h0);
        run_cmd(dpsf_pkg::OP_READ, 3'h3);
        check("left flag", 16'(f_q), 16'h1);
        dev.port_write(1, 3'h3, 1'b1);
        run_cmd(dpsf_pkg::OP_READ, 3'h3);
        check("freed", 16'(f_q), 16'h1);
        $display("test handover done");
    endtask
    task automatic t_failed();
        dev.port_write(1, 3'h5, 1'b0);
        run_cmd(dpsf_pkg::OP_CLAIM, 3'h5);
        check("granted", 16'(g_q), 16'h0);
        check("left flag", 16'(f_q), 16'h1);
        check("withdrawn", 16'(dev.req_n[0][5]), 16'h1);
        check("right keeps", 16'(dev.view(1, 3'h5)), 16'h0);
        dev.port_write(1, 3'h5, 1'b1);
        check("no late grant", 16'(dev.view(0, 3'h5)), 16'h1);
        $display("test failed claim done");
    endtask
    task automatic t_index();
        for (int i = 0; i < 8; i++) begin
            if (i % 2 == 1) begin
                dev.port_write(1, 3'(i), 1'b0);
            end else begin
                run_cmd(dpsf_pkg::OP_CLAIM, 3'(i));
                check("granted", 16'(g_q), 16'h1);
            end
        end
        for (int i = 0; i < 8; i++) begin
            run_cmd(dpsf_pkg::OP_READ, 3'(i));
            check("left flag", 16'(f_q), 16'(i % 2));
            dev.port_write(1, 3'(i), 1'b1);
        end
        run_cmd(dpsf_pkg::OP_INIT, 3'h0);
        check("freed", 16'(dev.view(0, 3'h6)), 16'h1);
        dev.bad_bus = 1'b1;
        run_cmd(dpsf_pkg::OP_READ, 3'h2);
        check("mixed bus", 16'(e_q), 16'h1);
        dev.bad_bus = 1'b0;
        $display("test index done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_init();
        t_handover();
        t_failed();
        t_index();
        stop_test();
    end
endmodule // tb
`default_nettype wire
